//--- design/pfbc_pkg.sv
// Package for the PLL0 feedback and loop configuration register bank.
// Assumes a byte-wide register port with 8-bit addresses on the system clock.
package pfbc_pkg;

	// Byte addresses of the bank.
	localparam logic [7:0] ADDR_RATIO0_HI   = 8'h17;
	localparam logic [7:0] ADDR_RATIO0_MID  = 8'h18;
	localparam logic [7:0] ADDR_RATIO0_LO   = 8'h19;
	localparam logic [7:0] ADDR_RATIO1_HI   = 8'h1a;
	localparam logic [7:0] ADDR_RATIO1_MID  = 8'h1b;
	localparam logic [7:0] ADDR_RATIO1_LO   = 8'h1c;
	localparam logic [7:0] ADDR_BANDWIDTH   = 8'h23;
	localparam logic [7:0] ADDR_DAMP_GAIN   = 8'h24;
	localparam logic [7:0] ADDR_SLEW_HOLD   = 8'h2f;
	localparam logic [7:0] ADDR_LOCK_WIN    = 8'h30;
	localparam logic [7:0] ADDR_MOD_INT_HI  = 8'h31;
	localparam logic [7:0] ADDR_MOD_INT_LO  = 8'h32;
	localparam logic [7:0] ADDR_MOD_FRAC_HI = 8'h33;
	localparam logic [7:0] ADDR_MOD_FRAC_MD = 8'h34;
	localparam logic [7:0] ADDR_MOD_FRAC_LO = 8'h35;
	localparam logic [7:0] ADDR_MOD_ORDER   = 8'h3a;

	// Reset values.
	localparam logic [23:0] RST_RATIO       = 24'h070000;
	localparam logic [3:0]  RST_BANDWIDTH   = 4'h7;
	localparam logic [2:0]  RST_DAMPING     = 3'h3;
	localparam logic [1:0]  RST_FILT_GAIN   = 2'h1;
	localparam logic [1:0]  RST_SLEW        = 2'h0;
	localparam logic [1:0]  RST_HOLD_MODE   = 2'h0;
	localparam logic        RST_HOLD_AVG    = 1'h0;
	localparam logic        RST_QUICK       = 1'h0;
	localparam logic [7:0]  RST_LOCK_WIN    = 8'h3f;
	localparam logic [8:0]  RST_MOD_INT     = 9'h02d;
	localparam logic [20:0] RST_MOD_FRAC    = 21'h000000;
	localparam logic [1:0]  RST_MOD_ORDER   = 2'h3;
	localparam logic [1:0]  RST_OSC_GAIN    = 2'h1;
	localparam logic [2:0]  RST_DITHER      = 3'h0;

	// Field positions within their bytes.
	localparam int POS_LCK_BW   = 4;
	localparam int POS_ACQ_BW   = 0;
	localparam int POS_LCK_DAMP = 5;
	localparam int POS_ACQ_DAMP = 2;
	localparam int POS_GAIN     = 0;
	localparam int POS_SLEW     = 6;
	localparam int POS_HOLD     = 3;
	localparam int POS_HOLD_AVG = 1;
	localparam int POS_QUICK    = 0;
	localparam int POS_ORDER    = 6;
	localparam int POS_OSC_GAIN = 4;
	localparam int POS_DITHER   = 0;

	// Legal code ranges and encodings.
	localparam logic [3:0] BW_CODE_MIN   = 4'h3;
	localparam logic [3:0] BW_CODE_MAX   = 4'hb;
	localparam logic [2:0] DAMP_CODE_MIN = 3'h1;
	localparam logic [2:0] DAMP_CODE_MAX = 3'h5;
	localparam logic [1:0] SLEW_RESERVED = 2'h3;

	// Lock window step in picoseconds, 2.5 ns per count.
	localparam int LOCK_STEP_PS = 2500;

endpackage : pfbc_pkg

//--- design/pfbc_loop_select.sv
// Chooses the bandwidth and damping codes that the loop filter uses now.
// Assumes phase_locked is synchronous to clk.
`timescale 1ns/1ps
module pfbc_loop_select (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       quick_acquire_enable,
	input  wire logic       phase_locked,
	input  wire logic [3:0] locked_bandwidth_code,
	input  wire logic [3:0] acquire_bandwidth_code,
	input  wire logic [2:0] locked_damping_code,
	input  wire logic [2:0] acquire_damping_code,
	output logic      [3:0] active_bandwidth_reg,
	output logic      [2:0] active_damping_reg,
	output logic            acquiring_reg
);

	// Acquisition codes only apply in quick mode before lock.
	wire use_acquire = quick_acquire_enable & ~phase_locked;

	// Registered so the filter sees glitch-free codes.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			active_bandwidth_reg <= pfbc_pkg::RST_BANDWIDTH;
			active_damping_reg   <= pfbc_pkg::RST_DAMPING;
			acquiring_reg        <= 1'b0;
		end else begin
			active_bandwidth_reg <= use_acquire ? acquire_bandwidth_code : locked_bandwidth_code;
			active_damping_reg   <= use_acquire ? acquire_damping_code : locked_damping_code;
			acquiring_reg        <= use_acquire;
		end
	end

	a_select_mode: assert property (@(posedge clk) disable iff (rst)
		!$past(quick_acquire_enable) |-> active_bandwidth_reg == $past(locked_bandwidth_code))
		else $error("Locked bandwidth not used with quick mode off.");

endmodule : pfbc_loop_select

//--- design/pfbc_bank.sv
// Register bank for PLL0 feedback ratios, loop filter and modulator settings.
// Assumes a byte-wide synchronous register port driven by the serial interface logic.
`timescale 1ns/1ps

module pfbc_bank (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        phase_locked,
	output logic      [7:0]  reg_rdata,
	output logic      [23:0] feedback_ratio_ref_zero,
	output logic      [23:0] feedback_ratio_ref_one,
	output logic      [3:0]  active_bandwidth,
	output logic      [2:0]  active_damping,
	output logic             acquiring,
	output logic      [1:0]  loop_filter_gain_code,
	output logic      [1:0]  phase_slope_limit,
	output logic      [1:0]  holdover_average_mode,
	output logic             holdover_average_enable,
	output logic      [7:0]  lock_window_size,
	output logic      [8:0]  modulator_integer,
	output logic      [20:0] modulator_fraction,
	output logic      [1:0]  modulator_order,
	output logic      [1:0]  oscillator_error_gain,
	output logic      [2:0]  dither_gain,
	output logic             code_fault
);

	////////////////////////////////////////////////////////////////////////////
	// Stored fields.

	logic [3:0] locked_bandwidth_code;  // Bandwidth once locked.
	logic [3:0] acquire_bandwidth_code; // Bandwidth while acquiring.
	logic [2:0] locked_damping_code;    // Damping once locked.
	logic [2:0] acquire_damping_code;   // Damping while acquiring.
	logic       quick_acquire_enable;   // Selects quick acquisition.

	// Write strobes, one per address.
	wire wr_r0h = reg_wr && reg_addr == pfbc_pkg::ADDR_RATIO0_HI;
	wire wr_r0m = reg_wr && reg_addr == pfbc_pkg::ADDR_RATIO0_MID;
	wire wr_r0l = reg_wr && reg_addr == pfbc_pkg::ADDR_RATIO0_LO;
	wire wr_r1h = reg_wr && reg_addr == pfbc_pkg::ADDR_RATIO1_HI;
	wire wr_r1m = reg_wr && reg_addr == pfbc_pkg::ADDR_RATIO1_MID;
	wire wr_r1l = reg_wr && reg_addr == pfbc_pkg::ADDR_RATIO1_LO;
	wire wr_bw  = reg_wr && reg_addr == pfbc_pkg::ADDR_BANDWIDTH;
	wire wr_dg  = reg_wr && reg_addr == pfbc_pkg::ADDR_DAMP_GAIN;
	wire wr_sh  = reg_wr && reg_addr == pfbc_pkg::ADDR_SLEW_HOLD;
	wire wr_lw  = reg_wr && reg_addr == pfbc_pkg::ADDR_LOCK_WIN;
	wire wr_ih  = reg_wr && reg_addr == pfbc_pkg::ADDR_MOD_INT_HI;
	wire wr_il  = reg_wr && reg_addr == pfbc_pkg::ADDR_MOD_INT_LO;
	wire wr_fh  = reg_wr && reg_addr == pfbc_pkg::ADDR_MOD_FRAC_HI;
	wire wr_fm  = reg_wr && reg_addr == pfbc_pkg::ADDR_MOD_FRAC_MD;
	wire wr_fl  = reg_wr && reg_addr == pfbc_pkg::ADDR_MOD_FRAC_LO;
	wire wr_or  = reg_wr && reg_addr == pfbc_pkg::ADDR_MOD_ORDER;

	////////////////////////////////////////////////////////////////////////////
	// Feedback ratios; each byte lands on its own write, no staging.

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			feedback_ratio_ref_zero <= pfbc_pkg::RST_RATIO;
			feedback_ratio_ref_one  <= pfbc_pkg::RST_RATIO;
		end else begin
			if (wr_r0h) feedback_ratio_ref_zero[23:16] <= reg_wdata;
			if (wr_r0m) feedback_ratio_ref_zero[15:8]  <= reg_wdata;
			if (wr_r0l) feedback_ratio_ref_zero[7:0]   <= reg_wdata;
			if (wr_r1h) feedback_ratio_ref_one[23:16]  <= reg_wdata;
			if (wr_r1m) feedback_ratio_ref_one[15:8]   <= reg_wdata;
			if (wr_r1l) feedback_ratio_ref_one[7:0]    <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Loop codes. Reserved codes are stored as written; the filter must not be
	// trusted with them, so code_fault flags them instead of silently fixing.

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			locked_bandwidth_code   <= pfbc_pkg::RST_BANDWIDTH;
			acquire_bandwidth_code  <= pfbc_pkg::RST_BANDWIDTH;
			locked_damping_code     <= pfbc_pkg::RST_DAMPING;
			acquire_damping_code    <= pfbc_pkg::RST_DAMPING;
			loop_filter_gain_code   <= pfbc_pkg::RST_FILT_GAIN;
		end else begin
			if (wr_bw) begin
				locked_bandwidth_code  <= reg_wdata[pfbc_pkg::POS_LCK_BW +: 4];
				acquire_bandwidth_code <= reg_wdata[pfbc_pkg::POS_ACQ_BW +: 4];
			end
			if (wr_dg) begin
				locked_damping_code   <= reg_wdata[pfbc_pkg::POS_LCK_DAMP +: 3];
				acquire_damping_code  <= reg_wdata[pfbc_pkg::POS_ACQ_DAMP +: 3];
				loop_filter_gain_code <= reg_wdata[pfbc_pkg::POS_GAIN +: 2];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Slew, holdover, lock window. Reserved bits are dropped on write.

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_slope_limit       <= pfbc_pkg::RST_SLEW;
			holdover_average_mode   <= pfbc_pkg::RST_HOLD_MODE;
			holdover_average_enable <= pfbc_pkg::RST_HOLD_AVG;
			quick_acquire_enable    <= pfbc_pkg::RST_QUICK;
			lock_window_size        <= pfbc_pkg::RST_LOCK_WIN;
		end else begin
			if (wr_sh) begin
				phase_slope_limit       <= reg_wdata[pfbc_pkg::POS_SLEW +: 2];
				holdover_average_mode   <= reg_wdata[pfbc_pkg::POS_HOLD +: 2];
				holdover_average_enable <= reg_wdata[pfbc_pkg::POS_HOLD_AVG];
				quick_acquire_enable    <= reg_wdata[pfbc_pkg::POS_QUICK];
			end
			if (wr_lw) lock_window_size <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Modulator and oscillator settings.

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			modulator_integer     <= pfbc_pkg::RST_MOD_INT;
			modulator_fraction    <= pfbc_pkg::RST_MOD_FRAC;
			modulator_order       <= pfbc_pkg::RST_MOD_ORDER;
			oscillator_error_gain <= pfbc_pkg::RST_OSC_GAIN;
			dither_gain           <= pfbc_pkg::RST_DITHER;
		end else begin
			if (wr_ih) modulator_integer[8]         <= reg_wdata[0];
			if (wr_il) modulator_integer[7:0]       <= reg_wdata;
			if (wr_fh) modulator_fraction[20:16]    <= reg_wdata[4:0];
			if (wr_fm) modulator_fraction[15:8]     <= reg_wdata;
			if (wr_fl) modulator_fraction[7:0]      <= reg_wdata;
			if (wr_or) begin
				modulator_order       <= reg_wdata[pfbc_pkg::POS_ORDER +: 2];
				oscillator_error_gain <= reg_wdata[pfbc_pkg::POS_OSC_GAIN +: 2];
				dither_gain           <= reg_wdata[pfbc_pkg::POS_DITHER +: 3];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read path. Reserved positions read zero, software must not rely on them.

	logic [7:0] rd_mux; // Combinational read value.
	always_comb begin
		rd_mux = 8'h00;
		unique case (reg_addr)
			pfbc_pkg::ADDR_RATIO0_HI:   rd_mux = feedback_ratio_ref_zero[23:16];
			pfbc_pkg::ADDR_RATIO0_MID:  rd_mux = feedback_ratio_ref_zero[15:8];
			pfbc_pkg::ADDR_RATIO0_LO:   rd_mux = feedback_ratio_ref_zero[7:0];
			pfbc_pkg::ADDR_RATIO1_HI:   rd_mux = feedback_ratio_ref_one[23:16];
			pfbc_pkg::ADDR_RATIO1_MID:  rd_mux = feedback_ratio_ref_one[15:8];
			pfbc_pkg::ADDR_RATIO1_LO:   rd_mux = feedback_ratio_ref_one[7:0];
			pfbc_pkg::ADDR_BANDWIDTH:   rd_mux = {locked_bandwidth_code, acquire_bandwidth_code};
			pfbc_pkg::ADDR_DAMP_GAIN:   rd_mux = {locked_damping_code, acquire_damping_code,
				loop_filter_gain_code};
			pfbc_pkg::ADDR_SLEW_HOLD:   rd_mux = {phase_slope_limit, 1'b0, holdover_average_mode,
				1'b0, holdover_average_enable, quick_acquire_enable};
			pfbc_pkg::ADDR_LOCK_WIN:    rd_mux = lock_window_size;
			pfbc_pkg::ADDR_MOD_INT_HI:  rd_mux = {7'h00, modulator_integer[8]};
			pfbc_pkg::ADDR_MOD_INT_LO:  rd_mux = modulator_integer[7:0];
			pfbc_pkg::ADDR_MOD_FRAC_HI: rd_mux = {3'h0, modulator_fraction[20:16]};
			pfbc_pkg::ADDR_MOD_FRAC_MD: rd_mux = modulator_fraction[15:8];
			pfbc_pkg::ADDR_MOD_FRAC_LO: rd_mux = modulator_fraction[7:0];
			pfbc_pkg::ADDR_MOD_ORDER:   rd_mux = {modulator_order, oscillator_error_gain, 1'b0,
				dither_gain};
			default:                    rd_mux = 8'h00;
		endcase
	end

	// Read data is held between reads so the serial shifter can sample it late.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) reg_rdata <= 8'h00;
		else if (reg_rd) reg_rdata <= rd_mux;
	end

	////////////////////////////////////////////////////////////////////////////
	// Reserved-code detection for the bandwidth and damping codes, slew and a zero lock window.

	wire bad_bw   = locked_bandwidth_code < pfbc_pkg::BW_CODE_MIN
		|| locked_bandwidth_code > pfbc_pkg::BW_CODE_MAX
		|| acquire_bandwidth_code < pfbc_pkg::BW_CODE_MIN
		|| acquire_bandwidth_code > pfbc_pkg::BW_CODE_MAX;
	wire bad_damp = locked_damping_code < pfbc_pkg::DAMP_CODE_MIN
		|| locked_damping_code > pfbc_pkg::DAMP_CODE_MAX
		|| acquire_damping_code < pfbc_pkg::DAMP_CODE_MIN
		|| acquire_damping_code > pfbc_pkg::DAMP_CODE_MAX;
	wire bad_misc = phase_slope_limit == pfbc_pkg::SLEW_RESERVED
		|| lock_window_size == 8'h00;

	// Registered fault flag, a plain level, not sticky.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) code_fault <= 1'b0;
		else code_fault <= bad_bw | bad_damp | bad_misc;
	end

	////////////////////////////////////////////////////////////////////////////
	// Active code selection.

	pfbc_loop_select u_select (
		.clk                    (clk),
		.rst                    (rst),
		.quick_acquire_enable   (quick_acquire_enable),
		.phase_locked           (phase_locked),
		.locked_bandwidth_code  (locked_bandwidth_code),
		.acquire_bandwidth_code (acquire_bandwidth_code),
		.locked_damping_code    (locked_damping_code),
		.acquire_damping_code   (acquire_damping_code),
		.active_bandwidth_reg   (active_bandwidth),
		.active_damping_reg     (active_damping),
		.acquiring_reg          (acquiring)
	);

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	a_ratio_zero_write: assert property (@(posedge clk) disable iff (rst)
		wr_r0l |=> feedback_ratio_ref_zero[7:0] == $past(reg_wdata))
		else $error("Ratio zero low byte not stored.");

	a_ratio_one_write: assert property (@(posedge clk) disable iff (rst)
		wr_r1h |=> feedback_ratio_ref_one[23:16] == $past(reg_wdata))
		else $error("Ratio one high byte not stored.");

	a_lock_bw_field: assert property (@(posedge clk) disable iff (rst)
		wr_bw |=> locked_bandwidth_code == $past(reg_wdata[7:4]))
		else $error("Locked bandwidth field misplaced.");

	a_acq_bw_field: assert property (@(posedge clk) disable iff (rst)
		wr_bw |=> acquire_bandwidth_code == $past(reg_wdata[3:0]))
		else $error("Acquire bandwidth field misplaced.");

	a_lock_damp_field: assert property (@(posedge clk) disable iff (rst)
		wr_dg |=> locked_damping_code == $past(reg_wdata[7:5]))
		else $error("Locked damping field misplaced.");

	a_acq_damp_field: assert property (@(posedge clk) disable iff (rst)
		wr_dg |=> acquire_damping_code == $past(reg_wdata[4:2]))
		else $error("Acquire damping field misplaced.");

	a_gain_field: assert property (@(posedge clk) disable iff (rst)
		wr_dg |=> loop_filter_gain_code == $past(reg_wdata[1:0]))
		else $error("Gain field misplaced.");

	sequence s_quick_unlocked;
		quick_acquire_enable && !phase_locked;
	endsequence
	a_quick_acquire: assert property (@(posedge clk) disable iff (rst)
		s_quick_unlocked |=> active_bandwidth == $past(acquire_bandwidth_code) && acquiring)
		else $error("Acquisition bandwidth not applied.");

	a_lock_window_zero: assert property (@(posedge clk) disable iff (rst)
		lock_window_size == 8'h00 |=> code_fault)
		else $error("Zero lock window not flagged.");

	a_slew_reserved: assert property (@(posedge clk) disable iff (rst)
		phase_slope_limit == pfbc_pkg::SLEW_RESERVED |=> code_fault)
		else $error("Reserved slew not flagged.");

	a_reserved_read: assert property (@(posedge clk) disable iff (rst)
		reg_rd && reg_addr == pfbc_pkg::ADDR_MOD_FRAC_HI |=> reg_rdata[7:5] == 3'h0)
		else $error("Reserved bits read nonzero.");

endmodule : pfbc_bank

//--- tb/tb_pll0_feedback_loop_config.sv
// Self-checking bench for the PLL0 feedback and loop configuration register bank.
// Assumes the bank's byte port, its one-cycle write and read latency and a 40 MHz clock.
`timescale 1ns/1ps

// Compares a design value with the value the bench expects and counts the outcome.
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fails++; \
	$display("ERROR %0t: value %h differs from expected %h", $time, (got), (exp)); end end

module tb_pll0_feedback_loop_config;

////////////////////////////////////////////////////////////////////////////////
	logic        clk;                     // System clock, 25 ns period.
	logic        rst;                     // Asynchronous reset, active high.
	logic        reg_wr;                  // Byte write strobe.
	logic        reg_rd;                  // Byte read strobe.
	logic [7:0]  reg_addr;                // Byte address.
	logic [7:0]  reg_wdata;               // Write data.
	logic        phase_locked;            // Lock level from the loop.
	logic [7:0]  reg_rdata;               // Registered read data.
	logic [23:0] ratio_zero, ratio_one;   // Feedback ratios.
	logic [3:0]  act_bw;                  // Bandwidth code in use.
	logic [2:0]  act_damp;                // Damping code in use.
	logic        acquiring;               // High while acquisition codes are in use.
	logic [1:0]  gain, slew, hold_mode;   // Small decoded fields.
	logic        hold_en;                 // Holdover averaging enable.
	logic [7:0]  lock_win;                // Lock window size.
	logic [8:0]  mod_int;                 // Modulator integer.
	logic [20:0] mod_frac;                // Modulator fraction.
	logic [1:0]  mod_order, osc_gain;     // Modulator order and oscillator gain.
	logic [2:0]  dither;                  // Dither gain.
	logic        code_fault;              // Reserved code flag.
	logic [7:0]  mem [0:255];             // Expected readback of every address.
	int          fails;                   // Mismatches seen.
	int          checks_done;             // Comparisons made.

	pfbc_bank dut (
		.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .phase_locked(phase_locked), .reg_rdata(reg_rdata),
		.feedback_ratio_ref_zero(ratio_zero), .feedback_ratio_ref_one(ratio_one),
		.active_bandwidth(act_bw), .active_damping(act_damp), .acquiring(acquiring),
		.loop_filter_gain_code(gain), .phase_slope_limit(slew),
		.holdover_average_mode(hold_mode), .holdover_average_enable(hold_en),
		.lock_window_size(lock_win), .modulator_integer(mod_int),
		.modulator_fraction(mod_frac), .modulator_order(mod_order),
		.oscillator_error_gain(osc_gain), .dither_gain(dither), .code_fault(code_fault)
	);

////////////////////////////////////////////////////////////////////////////////
	// Free-running clock; the half period is 12.5 ns.
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Writable bits of each address; reserved and unmapped places hold none.
	function automatic logic [7:0] wmask(input logic [7:0] a);
		case (a)
			8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h23, 8'h24, 8'h30, 8'h32, 8'h34,
			8'h35: return 8'hff;
			8'h2f: return 8'hdb;
			8'h31: return 8'h01;
			8'h33: return 8'h1f;
			8'h3a: return 8'hf7;
			default: return 8'h00;
		endcase
	endfunction : wmask

	// Reserved bandwidth and damping codes, used to predict the fault flag.
	function automatic logic bw_bad(input logic [3:0] c);
		return (c < 4'h3) || (c > 4'hb);
	endfunction : bw_bad

	function automatic logic damp_bad(input logic [2:0] c);
		return (c == 3'h0) || (c > 3'h5);
	endfunction : damp_bad

	// Loads the documented reset image into the expected map.
	task automatic reset_model();
		foreach (mem[i]) mem[i] = 8'h00;
		mem[8'h17] = 8'h07;
		mem[8'h1a] = 8'h07;
		mem[8'h23] = 8'h77;
		mem[8'h24] = 8'h6d;
		mem[8'h30] = 8'h3f;
		mem[8'h32] = 8'h2d;
		mem[8'h3a] = 8'hd0;
	endtask : reset_model

	// One byte write; every reserved bit, unmapped places included, goes out as zero.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d & wmask(a);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
		mem[a] = v & wmask(a);
	endtask : wr

	// One byte read, optionally with a write to the same place at the same edge.
	task automatic rd(input logic [7:0] a, input logic do_wr, input logic [7:0] d);
		logic [7:0] old;
		old = mem[a];
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_wr <= do_wr;
		reg_addr <= a;
		reg_wdata <= d & wmask(a);
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_wr <= 1'b0;
		if (do_wr) mem[a] = d & wmask(a);
		#1;
		`CHK(reg_rdata, old)
	endtask : rd

	// Lets writes and lock changes settle, then compares every output except reg_rdata.
	task automatic check_outs();
		logic acq;
		logic flt;
		repeat (3) @(posedge clk);
		#1;
		acq = mem[8'h2f][0] & ~phase_locked;
		flt = bw_bad(mem[8'h23][7:4]) | bw_bad(mem[8'h23][3:0]) | damp_bad(mem[8'h24][7:5]) |
			damp_bad(mem[8'h24][4:2]) | (mem[8'h2f][7:6] == 2'h3) | (mem[8'h30] == 8'h00);
		`CHK(ratio_zero, {mem[8'h17], mem[8'h18], mem[8'h19]})
		`CHK(ratio_one, {mem[8'h1a], mem[8'h1b], mem[8'h1c]})
		`CHK(act_bw, acq ? mem[8'h23][3:0] : mem[8'h23][7:4])
		`CHK(act_damp, acq ? mem[8'h24][4:2] : mem[8'h24][7:5])
		`CHK(acquiring, acq)
		`CHK(gain, mem[8'h24][1:0])
		`CHK({slew, hold_mode, hold_en}, {mem[8'h2f][7:6], mem[8'h2f][4:3], mem[8'h2f][1]})
		`CHK(lock_win, mem[8'h30])
		`CHK({mod_int, mod_frac}, {mem[8'h31][0], mem[8'h32], mem[8'h33][4:0], mem[8'h34],
			mem[8'h35]})
		`CHK({mod_order, osc_gain, dither}, {mem[8'h3a][7:6], mem[8'h3a][5:4], mem[8'h3a][2:0]})
		`CHK(code_fault, flt)
	endtask : check_outs

	// Reads back the whole window around the bank, unmapped places included.
	task automatic read_all();
		for (int a = 8'h14; a <= 8'h3c; a++) rd(a[7:0], 1'b0, 8'h00);
	endtask : read_all

	// Prints the verdict and ends the run.
	task automatic give_verdict();
		if (fails == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict

////////////////////////////////////////////////////////////////////////////////
	// Watchdog: the whole sequence needs well under 20000 cycles.
	initial begin
		#(25 * 20000);
		fails++;
		give_verdict();
	end

	// Main sequence: reset image, every bandwidth, damping, gain and slew code, lock switching, random traffic.
	initial begin
		logic [7:0] a;
		logic [7:0] amap [0:16];
		amap = '{8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h23, 8'h24, 8'h2f, 8'h30,
			8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h3a, 8'h25};
		{rst, reg_wr, reg_rd, reg_addr, reg_wdata, phase_locked} = '0;
		rst = 1'b1;
		fails = 0;
		checks_done = 0;
		void'($urandom(32'h9e6e));
		reset_model();
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		check_outs();
		read_all();
		// Every bandwidth code in both nibbles, the acquisition nibble in reverse.
		wr(8'h2f, 8'h01);
		for (int c = 0; c < 16; c++) begin
			wr(8'h23, {c[3:0], 4'hf - c[3:0]});
			check_outs();
		end
		// Every damping code, with each filter gain code in turn.
		for (int c = 0; c < 8; c++) begin
			wr(8'h24, {c[2:0], 3'h7 - c[2:0], c[1:0]});
			check_outs();
		end
		// Quick mode switching between acquisition and locked codes.
		wr(8'h23, 8'hb3);
		wr(8'h24, 8'ha7);
		@(posedge clk) phase_locked <= 1'b1;
		check_outs();
		@(posedge clk) phase_locked <= 1'b0;
		check_outs();
		wr(8'h2f, 8'h00);
		check_outs();
		// Every slew code, and the lock window at its boundaries.
		for (int c = 0; c < 4; c++) begin
			wr(8'h2f, {c[1:0], 6'h1b});
			check_outs();
		end
		foreach (amap[i]) if (i < 3) begin
			wr(8'h30, (i == 0) ? 8'h00 : ((i == 1) ? 8'h01 : 8'hff));
			check_outs();
		end
		// Write and read at the same edge returns the old byte.
		rd(8'h19, 1'b1, 8'haa);
		rd(8'h19, 1'b0, 8'h00);
		// Random traffic over mapped places and one unmapped place.
		for (int n = 0; n < 300; n++) begin
			a = amap[$urandom_range(0, 16)];
			@(posedge clk) phase_locked <= 1'($urandom_range(0, 1));
			wr(a, 8'($urandom_range(0, 255)));
			if (n % 10 == 0) check_outs();
		end
		check_outs();
		read_all();
		// Reset in mid-run restores the reset image.
		@(posedge clk) rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		reset_model();
		check_outs();
		read_all();
		give_verdict();
	end

endmodule : tb_pll0_feedback_loop_config
